// ==== verilog/tile_status_control_regs.sv ====
/*
 * Processor status register bank for one tile: tile control, boot status,
 * security word, ring oscillator control and four oscillator counts.
 * Assumes requests from the core on the tile clock, one at a time.
 */
// Summary of operation
// - Tile control bits 25:18 hold transmit data delay in clock cycles.
// - Transmit clock rises at counter equal divider, falls at half.
// - Tile control bit 8 enables the reduced-gigabit ports.
// - Tile control bit 4 enables the low-power clock divider.
// - Bit 5 set: divider acts only while all threads pause.
// - Boot status is read-only; bits 23:16 give processor number.
// - Boot status bit 3 boot from RAM, bit 2 from test port.
// - Boot status bit 5 shows second core powered off.
// - Boot status bits 1:0 hold sampled PLL mode straps.
// - Security register loads the word read from OTP.
// - Security bit 31 set refuses further writes there.
// - Security bit 14 disables global debug access.
// - Security bit 12 locks all OTP sectors; 11:8 lock each.
// - Security bit 5 forces boot image from OTP.
// - Security bit 4 blocks test port access to PLL/boot config.
// - Security bit 0 disables the debug test port controller.
// - Four free-running oscillators each clock a counter, started by software.
// - Ring control bit 1 core oscillators, bit 0 peripheral; reset zero.
// - Each count reads in bits 15:0 and survives reset.
// - Oscillators are asynchronous; their counts are synchronised.
`timescale 1ns/100ps
module tile_status_control_regs #(
    parameter int LP_DIV_RATIO = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input tile_status_pkg::ps_req_type psReq,
    output logic [31:0] psReadData,
    output logic psReadValid,
    output logic psWriteRefused,
    input wire logic [7:0] processorNumber,
    input wire logic bootFromRam,
    input wire logic bootFromTap,
    input wire logic noOtpPoll,
    input wire logic secondCorePoweredOff,
    input wire logic [1:0] pllStrapValue,
    input wire logic otpWordValid,
    input wire logic [31:0] otpWord,
    input wire logic allThreadsPaused,
    input wire logic [3:0] oscIn,
    output logic [3:0] oscEnable,
    output logic rgmiiPortsOn,
    output logic rgmiiTxClk,
    output logic rgmiiTxLaunch,
    output logic coreClockTick,
    output logic dividerActive,
    output tile_status_pkg::security_out_type securityOut
);
    import tile_status_pkg::*;

    localparam int LP_W = $clog2(LP_DIV_RATIO + 1);

    logic [31:0] tileControl_reg;
    logic [31:0] security_reg;
    logic [31:0] ringControl_reg;
    logic [31:0] bootStatus;
    logic [31:0] readMux;
    logic [7:0] regNum;
    logic typeOk;
    logic wrTile;
    logic wrSec;
    logic wrRing;
    logic [TXDELAY_W-1:0] txDelay;
    logic [TXDIV_W-1:0] txDiv;
    logic [TXDIV_W-1:0] txCount_reg;
    logic [TXDIV_W-1:0] txCount_next;
    logic [TXDELAY_W-1:0] launchCount_reg;
    logic launchPending_reg;
    logic [LP_W-1:0] lpCount_reg;
    logic [STRAP_W-1:0] strap1_reg;
    logic [STRAP_W-1:0] strap2_reg;
    logic [STRAP_W-1:0] strap3_reg;
    logic strapFill1_reg;
    logic strapFill2_reg;
    logic strapFill3_reg;
    logic [STRAP_W-1:0] strapHeld_reg;
    strap_state_type strapState_reg;
    logic [COUNT_W-1:0] oscCount [NUM_OSC];

    // Request decode
    assign regNum = psReq.resource[RES_NUM_LSB +: RES_NUM_W];
    assign typeOk = psReq.resource[7:0] == PS_RESOURCE_TYPE;
    assign wrTile = psReq.write && typeOk && regNum == REG_TILE_CONTROL;
    assign wrSec = psReq.write && typeOk && regNum == REG_SECURITY;
    assign wrRing = psReq.write && typeOk && regNum == REG_RING_CONTROL;

    // Tile control
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            tileControl_reg <= TILE_CONTROL_RESET;
        else if (wrTile)
            tileControl_reg <= psReq.wdata & TILE_CONTROL_WMASK;
    end

    assign txDelay = tileControl_reg[TXDELAY_LSB +: TXDELAY_W];
    assign txDiv = tileControl_reg[TXDIV_LSB +: TXDIV_W];
    assign rgmiiPortsOn = tileControl_reg[RGMII_EN_BIT];

    // Counter wraps after reaching the divider value: ratio is value plus one
    always_comb
    begin
        if (txCount_reg >= txDiv)
            txCount_next = '0;
        else
            txCount_next = txCount_reg + TXDIV_W'(1);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            txCount_reg <= '0;
        else if (!rgmiiPortsOn)
            txCount_reg <= '0;
        else
            txCount_reg <= txCount_next;
    end

    // Transmit clock edges; rise checked first so it wins when both match
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rgmiiTxClk <= 1'b0;
        else if (!rgmiiPortsOn)
            rgmiiTxClk <= 1'b0;
        else if (txCount_reg == txDiv)
            rgmiiTxClk <= 1'b1;
        else if (txCount_reg == (txDiv >> 1))
            rgmiiTxClk <= 1'b0;
    end

    // Data launch follows the rising edge by the programmed delay
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            launchPending_reg <= 1'b0;
            launchCount_reg <= '0;
            rgmiiTxLaunch <= 1'b0;
        end
        else if (!rgmiiPortsOn)
        begin
            launchPending_reg <= 1'b0;
            launchCount_reg <= '0;
            rgmiiTxLaunch <= 1'b0;
        end
        else if (txCount_reg == txDiv)
        begin
            launchPending_reg <= txDelay != '0;
            launchCount_reg <= txDelay;
            rgmiiTxLaunch <= txDelay == '0;
        end
        else if (launchPending_reg)
        begin
            launchCount_reg <= launchCount_reg - TXDELAY_W'(1);
            launchPending_reg <= launchCount_reg != TXDELAY_W'(1);
            rgmiiTxLaunch <= launchCount_reg == TXDELAY_W'(1);
        end
        else
            rgmiiTxLaunch <= 1'b0;
    end

    // Low-power divider
    assign dividerActive = tileControl_reg[DIV_EN_BIT]
        && (!tileControl_reg[DIV_DYN_BIT] || allThreadsPaused);

    // Tick every cycle at full speed, else once per LP_DIV_RATIO cycles
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lpCount_reg <= '0;
            coreClockTick <= 1'b0;
        end
        else if (!dividerActive)
        begin
            lpCount_reg <= '0;
            coreClockTick <= 1'b1;
        end
        else if (lpCount_reg == LP_W'(LP_DIV_RATIO - 1))
        begin
            lpCount_reg <= '0;
            coreClockTick <= 1'b1;
        end
        else
        begin
            lpCount_reg <= lpCount_reg + LP_W'(1);
            coreClockTick <= 1'b0;
        end
    end

    // Strap pins: three flops, captured once after reset when stable
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            strap1_reg <= '0;
            strap2_reg <= '0;
            strap3_reg <= '0;
            strapFill1_reg <= 1'b0;
            strapFill2_reg <= 1'b0;
            strapFill3_reg <= 1'b0;
        end
        else
        begin
            strap1_reg <= pllStrapValue;
            strap2_reg <= strap1_reg;
            strap3_reg <= strap2_reg;
            strapFill1_reg <= 1'b1;
            strapFill2_reg <= strapFill1_reg;
            strapFill3_reg <= strapFill2_reg;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            strapState_reg <= STRAP_WAIT;
            strapHeld_reg <= '0;
        end
        else
        begin
            case (strapState_reg)
                STRAP_WAIT:
                begin
                    // Reset zeros in the samplers are not pin values
                    if (strapFill3_reg && strap2_reg == strap3_reg)
                    begin
                        strapHeld_reg <= strap3_reg;
                        strapState_reg <= STRAP_HELD;
                    end
                end
                STRAP_HELD:
                    strapState_reg <= STRAP_HELD;
                default:
                    strapState_reg <= STRAP_WAIT;
            endcase
        end
    end

    // Boot status: assembled from live state, never written
    always_comb
    begin
        bootStatus = '0;
        bootStatus[PROC_LSB +: PROC_W] = processorNumber;
        bootStatus[SEC_BOOT_BIT] = security_reg[SEC_BOOT_OVR_BIT];
        bootStatus[CORE1_OFF_BIT] = secondCorePoweredOff;
        bootStatus[NO_OTP_POLL_BIT] = noOtpPoll;
        bootStatus[FROM_RAM_BIT] = bootFromRam;
        bootStatus[FROM_TAP_BIT] = bootFromTap;
        bootStatus[STRAP_LSB +: STRAP_W] = strapHeld_reg;
    end

    // Security word; the OTP copy wins over a same-cycle software write
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            security_reg <= SECURITY_RESET;
        else if (otpWordValid)
            security_reg <= otpWord & SECURITY_WMASK;
        else if (wrSec && !security_reg[SEC_LOCKOUT_BIT])
            security_reg <= psReq.wdata & SECURITY_WMASK;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            psWriteRefused <= 1'b0;
        else
            psWriteRefused <= wrSec && !otpWordValid
                && security_reg[SEC_LOCKOUT_BIT];
    end

    assign securityOut.globalDebugOff = security_reg[SEC_GDBG_BIT];
    assign securityOut.otpMasterLock = security_reg[SEC_MASTER_BIT];
    assign securityOut.otpSectorLock =
        security_reg[SEC_SECTOR_LSB +: SEC_SECTOR_W] | {SEC_SECTOR_W{
        security_reg[SEC_MASTER_BIT]}};
    assign securityOut.otpRedundancyOn = security_reg[SEC_REDUN_BIT];
    assign securityOut.secureBootOverride =
        security_reg[SEC_BOOT_OVR_BIT];
    assign securityOut.tapConfigBlock = security_reg[SEC_TAPCFG_BIT];
    assign securityOut.debugTapOff = security_reg[SEC_DBGTAP_BIT];

    // Ring oscillators
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ringControl_reg <= RING_RESET;
        else if (wrRing)
            ringControl_reg <= psReq.wdata & RING_WMASK;
    end

    // Oscillators 0 and 1 are the core pair, 2 and 3 the peripheral pair
    assign oscEnable = {{2{ringControl_reg[PERIPH_OSC_BIT]}},
        {2{ringControl_reg[CORE_OSC_BIT]}}};

    // Run gates the count flop directly, so a stop takes effect at once;
    // edges still in the samplers at that point are not counted
    genvar g;
    generate
        for (g = 0; g < NUM_OSC; g++)
        begin : oscUnit
            ring_osc_counter #(
                .WIDTH(COUNT_W)
            ) counter (
                .clk(clk),
                .rstn(rstn),
                .oscIn(oscIn[g]),
                .run(oscEnable[g]),
                .count(oscCount[g])
            );
        end
    endgenerate

    // Read side
    always_comb
    begin
        readMux = '0;
        if (typeOk)
        begin
            case (regNum)
                REG_TILE_CONTROL:
                    readMux = tileControl_reg;
                REG_BOOT_STATUS:
                    readMux = bootStatus;
                REG_SECURITY:
                    readMux = security_reg;
                REG_RING_CONTROL:
                    readMux = ringControl_reg;
                default:
                begin
                    if (regNum >= REG_COUNT_FIRST && regNum <= REG_COUNT_LAST)
                        readMux[COUNT_W-1:0] =
                            oscCount[2'(regNum - REG_COUNT_FIRST)];
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            psReadData <= '0;
            psReadValid <= 1'b0;
        end
        else
        begin
            psReadValid <= psReq.read;
            if (psReq.read)
                psReadData <= readMux;
        end
    end

endmodule

// ==== verilog/tile_status_pkg.sv ====
/*
 * Shared constants and types for the tile status register bank:
 * register numbers, field positions, write masks, reset values, carriers.
 * Assumes a single tile clock domain and a status-register request port.
 */
package tile_status_pkg;

    // Resource identifier layout: register number above a fixed type byte
    localparam int RES_NUM_LSB = 8;
    localparam int RES_NUM_W = 8;
    localparam logic [7:0] PS_RESOURCE_TYPE = 8'h0B;

    // Register numbers
    localparam logic [7:0] REG_TILE_CONTROL = 8'h02;
    localparam logic [7:0] REG_BOOT_STATUS = 8'h03;
    localparam logic [7:0] REG_SECURITY = 8'h05;
    localparam logic [7:0] REG_RING_CONTROL = 8'h06;
    localparam logic [7:0] REG_COUNT_FIRST = 8'h07;
    localparam logic [7:0] REG_COUNT_LAST = 8'h0A;

    // Tile control fields
    localparam int TXDELAY_LSB = 18;
    localparam int TXDELAY_W = 8;
    localparam int TXDIV_LSB = 9;
    localparam int TXDIV_W = 9;
    localparam int RGMII_EN_BIT = 8;
    localparam int DIV_DYN_BIT = 5;
    localparam int DIV_EN_BIT = 4;
    localparam logic [31:0] TILE_CONTROL_WMASK = 32'h03FF_FF30;
    localparam logic [31:0] TILE_CONTROL_RESET = 32'h0000_0000;

    // Boot status fields
    localparam int PROC_LSB = 16;
    localparam int PROC_W = 8;
    localparam int SEC_BOOT_BIT = 8;
    localparam int CORE1_OFF_BIT = 5;
    localparam int NO_OTP_POLL_BIT = 4;
    localparam int FROM_RAM_BIT = 3;
    localparam int FROM_TAP_BIT = 2;
    localparam int STRAP_LSB = 0;
    localparam int STRAP_W = 2;

    // Security fields
    localparam int SEC_LOCKOUT_BIT = 31;
    localparam int SEC_GDBG_BIT = 14;
    localparam int SEC_MASTER_BIT = 12;
    localparam int SEC_SECTOR_LSB = 8;
    localparam int SEC_SECTOR_W = 4;
    localparam int SEC_REDUN_BIT = 7;
    localparam int SEC_BOOT_OVR_BIT = 5;
    localparam int SEC_TAPCFG_BIT = 4;
    localparam int SEC_DBGTAP_BIT = 0;
    localparam logic [31:0] SECURITY_WMASK = 32'h8000_5FB1;
    localparam logic [31:0] SECURITY_RESET = 32'h0000_0000;

    // Ring oscillator control
    localparam int CORE_OSC_BIT = 1;
    localparam int PERIPH_OSC_BIT = 0;
    localparam logic [31:0] RING_WMASK = 32'h0000_0003;
    localparam logic [31:0] RING_RESET = 32'h0000_0000;
    localparam int NUM_OSC = 4;
    localparam int COUNT_W = 16;

    typedef struct packed {
        logic read;
        logic write;
        logic [15:0] resource;
        logic [31:0] wdata;
    } ps_req_type;

    typedef struct packed {
        logic globalDebugOff;
        logic otpMasterLock;
        logic [SEC_SECTOR_W-1:0] otpSectorLock;
        logic otpRedundancyOn;
        logic secureBootOverride;
        logic tapConfigBlock;
        logic debugTapOff;
    } security_out_type;

    typedef enum logic [1:0] {
        STRAP_WAIT = 2'b01,
        STRAP_HELD = 2'b10
    } strap_state_type;

endpackage

// ==== verilog/ring_osc_counter.sv ====
/*
 * One ring oscillator counter. The oscillator output is sampled as a
 * foreign input through three flops; each agreed rising edge counts.
 * Assumes the oscillator runs well below half the tile clock rate.
 */
`timescale 1ns/100ps
module ring_osc_counter #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic oscIn,
    input wire logic run,
    output logic [WIDTH-1:0] count
);
    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic level_reg;
    logic risen;
    // Stands for the unknown power-up state; reset never touches it
    logic [WIDTH-1:0] count_reg = '0;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= oscIn;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Edge counts only once two late stages agree
    assign risen = (sync2_reg == sync3_reg) && sync2_reg && !level_reg;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            level_reg <= 1'b0;
        else if (sync2_reg == sync3_reg)
            level_reg <= sync2_reg;
    end

    // No reset here: the count survives a system reset
    always_ff @(posedge clk)
    begin
        if (run && risen)
            count_reg <= count_reg + WIDTH'(1);
    end

    assign count = count_reg;

endmodule

// ==== tb/tile_status_control_regs_sva.sv ====
/*
 * Checker for the tile status bank, bound to the bank's ports.
 * Assumes one tile clock and an active-low asynchronous reset.
 */
`timescale 1ns/100ps
module tile_status_control_regs_sva #(
    parameter int LP_DIV_RATIO = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input tile_status_pkg::ps_req_type psReq,
    input wire logic psReadValid,
    input wire logic psWriteRefused,
    input wire logic otpWordValid,
    input wire logic [31:0] otpWord,
    input wire logic allThreadsPaused,
    input wire logic [3:0] oscEnable,
    input wire logic rgmiiPortsOn,
    input wire logic rgmiiTxClk,
    input wire logic coreClockTick,
    input wire logic dividerActive,
    input tile_status_pkg::security_out_type securityOut
);
    import tile_status_pkg::*;
    logic tileWr;
    logic ringWr;
    logic secWr;
    assign tileWr = psReq.write
        && psReq.resource == {REG_TILE_CONTROL, PS_RESOURCE_TYPE};
    assign ringWr = psReq.write
        && psReq.resource == {REG_RING_CONTROL, PS_RESOURCE_TYPE};
    assign secWr = psReq.write
        && psReq.resource == {REG_SECURITY, PS_RESOURCE_TYPE};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    a_read_answer: assert property (psReq.read |=> psReadValid)
        else $error("read request not answered");
    a_valid_cause: assert property (psReadValid |-> $past(psReq.read))
        else $error("read valid without request");
    a_ports_follow: assert property (tileWr |=>
        rgmiiPortsOn == $past(psReq.wdata[RGMII_EN_BIT]))
        else $error("port enable does not follow write");
    a_div_select: assert property (tileWr |=>
        dividerActive == ($past(psReq.wdata[DIV_EN_BIT])
        && (!$past(psReq.wdata[DIV_DYN_BIT]) || allThreadsPaused)))
        else $error("divider activity wrong after write");
    a_osc_follow: assert property (ringWr |=>
        oscEnable == {{2{$past(psReq.wdata[PERIPH_OSC_BIT])}},
        {2{$past(psReq.wdata[CORE_OSC_BIT])}}})
        else $error("oscillator enables wrong after write");
    a_refuse_cause: assert property (psWriteRefused |->
        $past(secWr) && $stable(securityOut))
        else $error("refusal without locked write");
    a_otp_copy: assert property (otpWordValid |=>
        securityOut.debugTapOff == $past(otpWord[SEC_DBGTAP_BIT])
        && securityOut.globalDebugOff == $past(otpWord[SEC_GDBG_BIT]))
        else $error("security outputs not loaded");
    a_master_lock: assert property (securityOut.otpMasterLock |->
        &securityOut.otpSectorLock)
        else $error("master lock leaves a sector open");
    // Window must lie after release: the tick is still zero at that edge
    a_tick_static: assert property ((rstn && !dividerActive)[*2] |->
        coreClockTick)
        else $error("tick missing while divider idle");
    a_txclk_idle: assert property (!rgmiiPortsOn[*2] |-> !rgmiiTxClk)
        else $error("transmit clock runs while disabled");
endmodule

bind tile_status_control_regs tile_status_control_regs_sva #(
    .LP_DIV_RATIO(LP_DIV_RATIO)
) i_sva (
    .clk(clk), .rstn(rstn), .psReq(psReq), .psReadValid(psReadValid),
    .psWriteRefused(psWriteRefused), .otpWordValid(otpWordValid),
    .otpWord(otpWord), .allThreadsPaused(allThreadsPaused),
    .oscEnable(oscEnable), .rgmiiPortsOn(rgmiiPortsOn),
    .rgmiiTxClk(rgmiiTxClk), .coreClockTick(coreClockTick),
    .dividerActive(dividerActive), .securityOut(securityOut)
);

// ==== tb/core_port_model.sv ====
/*
 * Core side model: issues one status request at a time.
 * Assumes the bank answers one cycle after each request.
 */
`timescale 1ns/100ps
module core_port_model (
    input wire logic clk,
    output tile_status_pkg::ps_req_type req,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic refused
);
    import tile_status_pkg::*;
    initial req = '0;
    // Request held a full cycle, answer taken once the next edge settles
    task automatic xfer(input logic rd, input logic [7:0] num,
        input logic [7:0] kind, input logic [31:0] wd,
        output logic [31:0] data, output logic flag);
        @(posedge clk);
        req <= '{rd, !rd, {num, kind}, wd};
        @(posedge clk);
        req <= '0;
        #1;
        data = rdata;
        flag = rd ? rvalid : refused;
    endtask
endmodule

// ==== tb/tile_status_control_regs_tb_top.sv ====
/*
 * Testbench for the tile status bank: register traffic, boot inputs,
 * OTP load, clock outputs and ring oscillators.
 * Assumes the core model and checker are compiled alongside.
 */
`timescale 1ns/100ps
module tile_status_control_regs_tb_top;
    import tile_status_pkg::*;
    logic clk = 0;
    logic rstn = 0;
    logic otpWordValid = 0;
    logic allThreadsPaused = 0;
    logic oscRaw = 0;
    logic fromRam = 1;
    logic fromTap = 0;
    logic noPoll = 0;
    logic core1Off = 1;
    logic [7:0] procNum = 8'hA5;
    logic [1:0] strap = 2'h2;
    logic [31:0] otpWord = 32'h0;
    logic [31:0] psReadData, d;
    logic [31:0] cnt [4];
    logic [3:0] oscEnable, oscIn;
    logic psReadValid, psWriteRefused, f;
    logic rgmiiPortsOn, rgmiiTxClk, rgmiiTxLaunch;
    logic coreClockTick, dividerActive;
    security_out_type securityOut;
    ps_req_type psReq;
    int bad_count = 0;
    int compares = 0;
    always #5 clk = ~clk;
    // Ring outputs stand still low while their enable is off
    always #37 oscRaw = ~oscRaw;
    assign oscIn = oscEnable & {4{oscRaw}};
    tile_status_control_regs #(
        .LP_DIV_RATIO(2)
    ) i_dut (
        .clk(clk), .rstn(rstn), .psReq(psReq), .psReadData(psReadData),
        .psReadValid(psReadValid), .psWriteRefused(psWriteRefused),
        .processorNumber(procNum), .bootFromRam(fromRam),
        .bootFromTap(fromTap), .noOtpPoll(noPoll),
        .secondCorePoweredOff(core1Off), .pllStrapValue(strap),
        .otpWordValid(otpWordValid), .otpWord(otpWord),
        .allThreadsPaused(allThreadsPaused), .oscIn(oscIn),
        .oscEnable(oscEnable), .rgmiiPortsOn(rgmiiPortsOn),
        .rgmiiTxClk(rgmiiTxClk), .rgmiiTxLaunch(rgmiiTxLaunch),
        .coreClockTick(coreClockTick), .dividerActive(dividerActive),
        .securityOut(securityOut)
    );
    core_port_model i_core (
        .clk(clk), .req(psReq), .rdata(psReadData),
        .rvalid(psReadValid), .refused(psWriteRefused)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic rd(input logic [7:0] n, output logic [31:0] v);
        logic ok;
        i_core.xfer(1'b1, n, PS_RESOURCE_TYPE, 32'h0, v, ok);
        chk1(ok, 1'b1);
    endtask
    task automatic rdc(input logic [7:0] n, input logic [31:0] exp);
        logic [31:0] v;
        rd(n, v);
        chk(v, exp);
    endtask
    task automatic wr(input logic [7:0] n, input logic [31:0] w,
        output logic refusedFlag);
        logic [31:0] v;
        i_core.xfer(1'b0, n, PS_RESOURCE_TYPE, w, v, refusedFlag);
    endtask
    // Ratio 4 transmit clock with launch two cycles after each rise;
    // early samples skipped while the counter leaves the old divider
    task automatic watch(input int ticks);
        logic [2:0] h;
        int t, r, l;
        t = 0;
        r = 0;
        l = 0;
        h = '0;
        for (int i = 0; i < 24; i++)
        begin
            @(posedge clk);
            #1;
            if (i >= 8)
            begin
                t += coreClockTick;
                r += rgmiiTxClk & !h[0];
                l += rgmiiTxLaunch & h[1] & !h[2];
            end
            h = {h[1:0], rgmiiTxClk};
        end
        chk(t, ticks);
        chk(r, 4);
        chk(l, 4);
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1;
        repeat (8) @(posedge clk);
        rdc(REG_TILE_CONTROL, TILE_CONTROL_RESET);
        rdc(REG_RING_CONTROL, RING_RESET);
        rdc(REG_SECURITY, SECURITY_RESET);
        rdc(REG_BOOT_STATUS, 32'h00A5_002A);
        wr(REG_BOOT_STATUS, 32'hFFFF_FFFF, f);
        fromRam <= 0;
        fromTap <= 1;
        rdc(REG_BOOT_STATUS, 32'h00A5_0026);
        rdc(8'h04, 32'h0);
        i_core.xfer(1'b0, REG_TILE_CONTROL, 8'h0C, '1, d, f);
        rdc(REG_TILE_CONTROL, 32'h0);
        i_core.xfer(1'b1, REG_BOOT_STATUS, 8'h0C, 32'h0, d, f);
        chk(d, 32'h0);
        wr(REG_TILE_CONTROL, '1, f);
        rdc(REG_TILE_CONTROL, TILE_CONTROL_WMASK);
        chk1(rgmiiPortsOn, 1'b1);
        wr(REG_SECURITY, '1, f);
        chk1(f, 1'b0);
        rdc(REG_SECURITY, SECURITY_WMASK);
        chk({22'h0, securityOut}, 32'h3FF);
        rdc(REG_BOOT_STATUS, 32'h00A5_0126);
        wr(REG_SECURITY, 32'h0, f);
        chk1(f, 1'b1);
        rdc(REG_SECURITY, SECURITY_WMASK);
        @(posedge clk);
        otpWordValid <= 1;
        otpWord <= 32'h0000_1011;
        @(posedge clk);
        otpWordValid <= 0;
        rdc(REG_SECURITY, 32'h0000_1011);
        chk({22'h0, securityOut}, 32'h1F3);
        allThreadsPaused <= 1;
        wr(REG_TILE_CONTROL, 32'h0008_0700, f);
        watch(16);
        wr(REG_TILE_CONTROL, 32'h0008_0730, f);
        watch(8);
        allThreadsPaused <= 0;
        watch(16);
        wr(REG_TILE_CONTROL, 32'h0008_0710, f);
        watch(8);
        wr(REG_RING_CONTROL, '1, f);
        rdc(REG_RING_CONTROL, RING_WMASK);
        chk({28'h0, oscEnable}, 32'hF);
        repeat (200) @(posedge clk);
        wr(REG_RING_CONTROL, 32'h1, f);
        chk({28'h0, oscEnable}, 32'hC);
        wr(REG_RING_CONTROL, 32'h0, f);
        repeat (10) @(posedge clk);
        for (int k = 0; k < 4; k++)
        begin
            rd(REG_COUNT_FIRST + 8'(k), cnt[k]);
            chk1(cnt[k] inside {[20:40]}, 1'b1);
        end
        wr(REG_RING_CONTROL, 32'h2, f);
        chk({28'h0, oscEnable}, 32'h3);
        repeat (100) @(posedge clk);
        wr(REG_RING_CONTROL, 32'h0, f);
        repeat (10) @(posedge clk);
        rd(REG_COUNT_LAST, d);
        chk(d, cnt[3]);
        rd(REG_COUNT_FIRST, d);
        chk1(d > cnt[0], 1'b1);
        rstn <= 0;
        repeat (3) @(posedge clk);
        rstn <= 1;
        repeat (8) @(posedge clk);
        rdc(REG_COUNT_FIRST, d);
        rdc(REG_TILE_CONTROL, TILE_CONTROL_RESET);
        end_of_test;
    end
    initial
    begin
        #50000;
        bad_count++;
        end_of_test;
    end
endmodule
